// >>> rtl/sdram_bank_address_mapper.sv
// module: maps host byte addresses onto sdram bank selects and row/column phases
`timescale 1ns/1ps
module sdram_bank_address_mapper (
	input  wire logic                                          clk_i,
	input  wire logic                                          rst_n_i,
	input  wire sdram_map_pkg::host_req_t                      req_i,
	input  wire sdram_map_pkg::dev_mode_t                      mode_i,
	input  wire logic [sdram_map_pkg::BANKS*sdram_map_pkg::BSIZE_W-1:0] bank_mb_i,
	input  wire logic [sdram_map_pkg::BSIZE_W-1:0]             gfx_mb_i,
	output logic                                               valid_o,
	output sdram_map_pkg::mem_addr_t                           map_o,
	output logic                                               gfx_err_o
);

	// ****************************************
	// bank decode
	// ****************************************
	logic [sdram_map_pkg::HADDR_W-1:0]                 phys;
	logic [sdram_map_pkg::BANKS-1:0]                   sel;
	logic [sdram_map_pkg::HADDR_W-1:0]                 local_addr;
	logic [sdram_map_pkg::SUM_W-1:0]                   base_mb [sdram_map_pkg::BANKS+1];
	logic [sdram_map_pkg::BANKS-1:0]                   usable;
	logic [sdram_map_pkg::SUM_W-1:0]                   addr_mb;
	logic [sdram_map_pkg::SUM_W-1:0]                   total_mb;

	// one bit wider so a host offset past the top cannot wrap into graphics
	logic [sdram_map_pkg::HADDR_W:0]                   phys_sum;

	// host memory above graphics: host offset shifted past the graphics region
	always_comb begin
		phys_sum = {1'b0, req_i.addr};
		if (!req_i.is_gfx) begin
			phys_sum = {1'b0, req_i.addr} + {gfx_mb_i, {sdram_map_pkg::MB_SHIFT{1'b0}}};
		end
	end

	assign phys    = phys_sum[sdram_map_pkg::HADDR_W-1:0];
	assign addr_mb = sdram_map_pkg::SUM_W'(phys_sum >> sdram_map_pkg::MB_SHIFT);

	// large devices free the upper two selects for address use
	assign usable = (mode_i == sdram_map_pkg::MODE_16M) ? 4'hF : 4'h3;

	assign base_mb[0] = '0;
	genvar g;
	generate
		for (g = 0; g < sdram_map_pkg::BANKS; g++) begin : g_bank
			logic [sdram_map_pkg::SUM_W-1:0] sz;
			assign sz = usable[g] ? sdram_map_pkg::SUM_W'(
				bank_mb_i[g*sdram_map_pkg::BSIZE_W +: sdram_map_pkg::BSIZE_W]) : '0;
			assign base_mb[g+1] = base_mb[g] + sz;
			assign sel[g] = (sz != '0) && (addr_mb >= base_mb[g])
				&& (addr_mb < base_mb[g+1]);
		end
	endgenerate

	// capacity capped at the documented maximum
	assign total_mb = (base_mb[sdram_map_pkg::BANKS] > sdram_map_pkg::SUM_W'(sdram_map_pkg::MAX_MB))
		? sdram_map_pkg::SUM_W'(sdram_map_pkg::MAX_MB) : base_mb[sdram_map_pkg::BANKS];

	always_comb begin
		local_addr = phys;
		for (int i = 0; i < sdram_map_pkg::BANKS; i++) begin
			if (sel[i]) begin
				local_addr = phys - sdram_map_pkg::HADDR_W'(
					{base_mb[i][sdram_map_pkg::BSIZE_W-1:0], {sdram_map_pkg::MB_SHIFT{1'b0}}});
			end
		end
	end

	// ****************************************
	// address phase mapping
	// ****************************************
	sdram_map_pkg::mem_addr_t nxt_map;
	logic                     nxt_valid;
	logic                     nxt_gfx_err;
	sdram_map_pkg::mem_addr_t map_ff;
	logic                     valid_ff;
	logic                     gfx_err_ff;

	// all transfers use the full 64-bit path, so byte lanes below A3 never reach MA
	always_comb begin
		nxt_map = '0;
		nxt_map.cs_n = '1;
		nxt_map.hit = (|sel) && (addr_mb < total_mb) && req_i.valid;
		nxt_valid = req_i.valid;
		nxt_gfx_err = req_i.valid && req_i.is_gfx
			&& (addr_mb >= sdram_map_pkg::SUM_W'(gfx_mb_i));
		nxt_map.bs_lo = local_addr[sdram_map_pkg::A_BANK0];
		nxt_map.col[7:0] = local_addr[10:sdram_map_pkg::A_COL_LO];
		case (mode_i)
			sdram_map_pkg::MODE_16M: begin
				nxt_map.row[10:0] = local_addr[22:sdram_map_pkg::A_ROW16_LO];
				nxt_map.col[9:8]  = local_addr[24:sdram_map_pkg::A_COL16_HI];
			end
			sdram_map_pkg::MODE_BIG_2IB: begin
				nxt_map.row[12:0] = local_addr[24:sdram_map_pkg::A_ROW2_LO];
				nxt_map.col[9:8]  = local_addr[26:sdram_map_pkg::A_COLBIG_HI];
			end
			sdram_map_pkg::MODE_BIG_4IB: begin
				nxt_map.bs_hi     = local_addr[sdram_map_pkg::A_BANK1];
				nxt_map.row[11:0] = local_addr[24:sdram_map_pkg::A_ROW4_LO];
				nxt_map.col[9:8]  = local_addr[26:sdram_map_pkg::A_COLBIG_HI];
			end
			default: begin
				nxt_map.hit = 1'b0;
			end
		endcase
		if (nxt_map.hit) begin
			nxt_map.cs_n = ~sel;
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			map_ff     <= '{row: '0, col: '0, bs_lo: 1'b0, bs_hi: 1'b0, cs_n: 4'hF, hit: 1'b0};
			valid_ff   <= 1'b0;
			gfx_err_ff <= 1'b0;
		end else begin
			map_ff     <= nxt_map;
			valid_ff   <= nxt_valid;
			gfx_err_ff <= nxt_gfx_err;
		end
	end

	// in large modes cs_n[2]/[3] are not selects; the pin mux outside takes row/col bits
	assign map_o     = map_ff;
	assign valid_o   = valid_ff;
	assign gfx_err_o = gfx_err_ff;

endmodule : sdram_bank_address_mapper

// >>> rtl/sdram_map_pkg.sv
// package: constants and carriers for the sdram bank address mapper
//
// Summary of operation
// - up to 128 MB total memory supported
// - every bank presents 64-bit data path
// - 16-Mbit mode gives four bank selects
// - 64/128-Mbit mode addresses two banks only
// - third/fourth selects reused as address lines
// - graphics memory starts at bank 0 base
// - host memory sits above graphics region
// - 16-Mbit row/column/bank address mapping
// - 64/128-Mbit two-internal-bank address mapping
// - 64/128-Mbit four-internal-bank address mapping
package sdram_map_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int HADDR_W     = 27;
	localparam int MA_W        = 13;
	localparam int DATA_W      = 64;
	localparam int BANKS       = 4;
	localparam int BSIZE_W     = 8;
	localparam int BYTE_OFS    = 3;
	localparam int MAX_MB      = 128;
	localparam int MB_SHIFT    = 20;
	localparam int BANKS_LARGE = 2;
	localparam int SUM_W       = 10;

	// ****************************************
	// host address bit positions
	// ****************************************
	localparam int A_BANK0     = 11;
	localparam int A_BANK1     = 12;
	localparam int A_ROW16_LO  = 12;
	localparam int A_COL_LO    = 3;
	localparam int A_ROW2_LO   = 12;
	localparam int A_ROW4_LO   = 13;
	localparam int A_COL16_HI  = 23;
	localparam int A_COLBIG_HI = 25;

	typedef enum logic [1:0] {
		MODE_16M,
		MODE_BIG_2IB,
		MODE_BIG_4IB
	} dev_mode_t;

	// one access request
	typedef struct packed {
		logic               valid;
		logic [HADDR_W-1:0] addr;
		logic               is_gfx;
	} host_req_t;

	// memory side address phases and selects
	typedef struct packed {
		logic [MA_W-1:0]  row;
		logic [MA_W-1:0]  col;
		logic             bs_lo;
		logic             bs_hi;
		logic [BANKS-1:0] cs_n;
		logic             hit;
	} mem_addr_t;

endpackage : sdram_map_pkg

// >>> verif/sdram_map_model.sv
// far-side model: which bank row the selects pick
`timescale 1ns/1ps
module sdram_map_model (
	input  wire sdram_map_pkg::mem_addr_t map_i,
	output logic [1:0]                    bank_o
);
	// lowest low select wins; a double select shows up in the checker
	always_comb begin
		bank_o = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (!map_i.cs_n[i]) begin
				bank_o = i[1:0];
			end
		end
	end
endmodule : sdram_map_model

// >>> verif/sdram_map_asserts.sv
// checker: select and phase properties of the mapper
`timescale 1ns/1ps
module sdram_map_chk (
	input wire logic                      clk_i,
	input wire logic                      rst_n_i,
	input wire sdram_map_pkg::host_req_t  req_i,
	input wire sdram_map_pkg::dev_mode_t  mode_i,
	input wire logic [31:0]               bank_mb_i,
	input wire logic [7:0]                gfx_mb_i,
	input wire logic                      valid_o,
	input wire sdram_map_pkg::mem_addr_t  map_o,
	input wire logic                      gfx_err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_hit_onesel: assert property (map_o.hit |-> $onehot(~map_o.cs_n))
		else $error("select count");
	a_miss_nosel: assert property (!map_o.hit |-> map_o.cs_n == 4'hF)
		else $error("miss select");
	a_big_twobank: assert property ($past(mode_i) != 2'h0 |-> map_o.cs_n[3:2] == 2'h3)
		else $error("upper select");
	a_col_low: assert property (map_o.hit |-> map_o.col[7:0] == $past(req_i.addr[10:3]))
		else $error("column low");
	a_bank_lo: assert property (map_o.hit |-> map_o.bs_lo == $past(req_i.addr[11]))
		else $error("bank lo");
	a_col_zero: assert property (map_o.hit |-> map_o.col[12:10] == 3'h0)
		else $error("column top");
	a_bank_hi: assert property (map_o.hit && $past(mode_i) == 2'h2
		|-> map_o.bs_hi == $past(req_i.addr[12])) else $error("bank hi");
	a_gfx_base: assert property (map_o.hit && $past(req_i.is_gfx) |-> map_o.cs_n == 4'hE)
		else $error("gfx bank");
	a_valid_lat: assert property ($past(rst_n_i) |-> valid_o == $past(req_i.valid))
		else $error("valid latency");
	a_hit_valid: assert property (map_o.hit |-> valid_o)
		else $error("hit without request");
endmodule : sdram_map_chk
bind sdram_bank_address_mapper sdram_map_chk u_chk (.clk_i, .rst_n_i, .req_i, .mode_i,
	.bank_mb_i, .gfx_mb_i, .valid_o, .map_o, .gfx_err_o);

// >>> verif/sdram_bank_address_mapper_bench.sv
// bench: directed mapping scenarios
`timescale 1ns/1ps
module sdram_bank_address_mapper_bench;
	logic                      clk_i = 1'b0;
	logic                      rst_n_i = 1'b0;
	sdram_map_pkg::host_req_t  req_i = '0;
	sdram_map_pkg::dev_mode_t  mode_i = sdram_map_pkg::MODE_16M;
	logic [31:0]               bank_mb_i = '0;
	logic [7:0]                gfx_mb_i = '0;
	logic                      valid_o;
	logic                      gfx_err_o;
	logic [1:0]                bank;
	sdram_map_pkg::mem_addr_t  map_o;
	int                        fail_count = 0;
	int                        checks_done = 0;
	int                        cyc = 0;
	sdram_bank_address_mapper DUT (.clk_i, .rst_n_i, .req_i, .mode_i, .bank_mb_i, .gfx_mb_i,
		.valid_o, .map_o, .gfx_err_o);
	sdram_map_model far (.map_i(map_o), .bank_o(bank));
	initial forever #12.5 clk_i = ~clk_i;
	task final_report;
		if (fail_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 400) begin
			fail_count++;
			final_report();
		end
	end
	task cmp(input logic [32:0] g, input logic [32:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	// result is settled one falling edge after the sampling edge
	task put(input logic [1:0] m, input logic [26:0] a, input logic g);
		@(negedge clk_i);
		mode_i = sdram_map_pkg::dev_mode_t'(m);
		req_i = '{1'b1, a, g};
		@(negedge clk_i);
	endtask : put
	task four_banks;
		bank_mb_i = 32'h08080808;
		gfx_mb_i = 8'h02;
		put(2'h0, 27'h11A5A38, 1'b0);
		cmp(map_o, {13'h03A5, 13'h0047, 1'b1, 1'b0, 4'hB, 1'b1});
		cmp(bank, 2'h2);
		cmp(valid_o, 1'b1);
	endtask : four_banks
	task two_ib;
		bank_mb_i = 32'h08082020;
		gfx_mb_i = 8'h04;
		put(2'h1, 27'h0000018, 1'b1);
		cmp(map_o, {13'h0000, 13'h0003, 1'b0, 1'b0, 4'hE, 1'b1});
		put(2'h1, 27'h31BC800, 1'b0);
		cmp(map_o, {13'h15BC, 13'h0000, 1'b1, 1'b0, 4'hD, 1'b1});
		put(2'h1, 27'h3C007F8, 1'b0);
		cmp(map_o[4:0], 5'h1E);
		put(2'h1, 27'h0400000, 1'b1);
		cmp(gfx_err_o, 1'b1);
	endtask : two_ib
	// mid-run reset, then an idle request
	task reset_mid;
		@(negedge clk_i);
		rst_n_i = 1'b0;
		@(negedge clk_i);
		cmp(map_o, {13'h0000, 13'h0000, 1'b0, 1'b0, 4'hF, 1'b0});
		cmp({valid_o, gfx_err_o}, 2'h0);
		rst_n_i = 1'b1;
		req_i.valid = 1'b0;
		@(negedge clk_i);
		cmp({valid_o, gfx_err_o, map_o[4:0]}, 7'h1E);
	endtask : reset_mid
	task four_ib;
		bank_mb_i = 32'h00000010;
		gfx_mb_i = 8'h00;
		put(2'h2, 27'h0C03FF8, 1'b0);
		cmp(map_o, {13'h0601, 13'h00FF, 1'b1, 1'b1, 4'hE, 1'b1});
		put(2'h3, 27'h0C03FF8, 1'b0);
		cmp(map_o[4:0], 5'h1E);
	endtask : four_ib
	task cap;
		bank_mb_i = 32'h40404040;
		gfx_mb_i = 8'h08;
		put(2'h0, 27'h7C00000, 1'b0);
		cmp(map_o[4:0], 5'h1E);
		put(2'h0, 27'h3C00000, 1'b0);
		cmp(map_o, {13'h0400, 13'h0000, 1'b0, 1'b0, 4'hD, 1'b1});
	endtask : cap
	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		four_banks();
		two_ib();
		reset_mid();
		four_ib();
		cap();
		final_report();
	end
endmodule : sdram_bank_address_mapper_bench
